/* File: hdl/scap_pkg.sv */
// constants for the strap configuration and alarm pin block
package scap_pkg;
    localparam int STRAP_COUNT = 8;
    localparam int DRIVE_COUNT = 4;
    localparam int PAT_LEN = 8;
    // six-valued class of one strap: ground, supply, or one of four drives
    typedef enum logic [2:0] {
        SCAP_TIE_LOW,
        SCAP_TIE_HIGH,
        SCAP_DRIVE_0,
        SCAP_DRIVE_1,
        SCAP_DRIVE_2,
        SCAP_DRIVE_3
    } scap_class_t;
    // distinct walking patterns on the four drives, one bit per step
    localparam logic [PAT_LEN-1:0] PAT_DRIVE_0 = 8'h0F;
    localparam logic [PAT_LEN-1:0] PAT_DRIVE_1 = 8'h33;
    localparam logic [PAT_LEN-1:0] PAT_DRIVE_2 = 8'h55;
    localparam logic [PAT_LEN-1:0] PAT_DRIVE_3 = 8'h3C;
    localparam logic [PAT_LEN-1:0] PAT_LOW = 8'h00;
    localparam logic [PAT_LEN-1:0] PAT_HIGH = 8'hFF;
    // register bus map
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
endpackage

/* File: hdl/scap_strap_config.sv */
// strap classification, latched configuration, alarms and lock indicator
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module scap_strap_config
    import scap_pkg::*;
#(
    parameter int PHASE_W = 8
) (
    input wire logic clk_i, // 20 MHz core clock
    input wire logic reset_i, // power-up reset, async, active high
    input wire logic system_reset_n_i, // external system reset, active low
    input wire logic [scap_pkg::STRAP_COUNT-1:0] strap_in_i, // strap input levels
    input wire logic ref_a_fail_i, // reference a activity lost
    input wire logic ref_b_fail_i, // reference b activity lost
    input wire logic ref_b_selected_i, // reference b is the selected one
    input wire logic [PHASE_W-1:0] phase_error_i, // phase detector error magnitude
    input wire logic [3:0] avs_address_i, // avalon byte address
    input wire logic avs_read_i, // avalon read
    input wire logic avs_write_i, // avalon write
    input wire logic [31:0] avs_writedata_i, // avalon write data
    input wire logic [3:0] avs_byteenable_i, // avalon byte enables
    output logic [31:0] avs_readdata_o, // avalon read data
    output logic avs_waitrequest_o, // avalon wait request
    output logic ref_a_fail_strap_drive_o, // ref a alarm / strap drive 0
    output logic ref_b_fail_strap_drive_o, // ref b alarm / strap drive 1
    output logic strap_drive_2_o, // strap drive 2
    output logic selected_ref_fail_strap_drive_o, // selected ref alarm / strap drive 3
    output logic phase_lock_indicator_o, // lock pulse output
    output logic config_busy_o, // configuration phase running
    output logic [3:0] rate_set_ab_o, // rate set code, outputs a and b
    output logic [3:0] divider_pad_ab_o, // divider and pad code, outputs a and b
    output logic [3:0] sync_freq_cd_o, // sync edge and c/d frequency code
    output logic [3:0] odd_lock_pad_cd_o // odd divider, lock enable, pad c/d code
);
    import scap_pkg::*;

    initial begin
        if (PHASE_W < 1 || PHASE_W > 16) begin
            $error("PHASE_W must be 1 to 16");
        end
        if (PAT_LEN < 2) begin
            $error("pattern length must be at least 2");
        end
    end

    typedef enum logic [1:0] {
        SCAP_IDLE,
        SCAP_DRIVE,
        SCAP_RUN
    } scap_state_t;

    localparam int STEP_W = $clog2(PAT_LEN);
    localparam int CLS_W = 3;

    scap_state_t state;
    logic [STEP_W-1:0] step;
    logic sys_reset_seen;
    logic [PAT_LEN-1:0] capture [STRAP_COUNT];
    logic [CLS_W-1:0] strap_class [STRAP_COUNT];
    logic [31:0] control;
    logic [PHASE_W-1:0] pwm_count;
    logic lock_enable;

    // a system reset pulse re-arms configuration once it is released
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sys_reset_seen <= 1'b1;
        end else if (!system_reset_n_i) begin
            sys_reset_seen <= 1'b1;
        end else if (state == SCAP_IDLE && sys_reset_seen) begin
            sys_reset_seen <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= SCAP_IDLE;
        end else if (!system_reset_n_i) begin
            state <= SCAP_IDLE;
        end else begin
            unique case (state)
                SCAP_IDLE: begin
                    if (sys_reset_seen) begin
                        state <= SCAP_DRIVE;
                    end
                end
                SCAP_DRIVE: begin
                    if (step == STEP_W'(PAT_LEN - 1)) begin
                        state <= SCAP_RUN;
                    end
                end
                SCAP_RUN: begin
                    state <= SCAP_RUN;
                end
            endcase
        end
    end

    // step only counts inside the drive phase, so each phase starts at step zero with the top pattern bit
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            step <= '0;
        end else if (!system_reset_n_i) begin
            step <= '0;
        end else if (state == SCAP_DRIVE) begin
            step <= step + 1'b1;
        end else begin
            step <= '0;
        end
    end

    // inputs sampled one step after each drive update, so each capture bit
    // sees the pattern bit driven in the previous cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < STRAP_COUNT; i++) begin
                capture[i] <= '0;
            end
        end else if (state == SCAP_DRIVE && step != '0) begin
            for (int i = 0; i < STRAP_COUNT; i++) begin
                capture[i] <= {capture[i][PAT_LEN-2:0], strap_in_i[i]};
            end
        end else if (state == SCAP_RUN && config_busy_o) begin
            for (int i = 0; i < STRAP_COUNT; i++) begin
                capture[i] <= {capture[i][PAT_LEN-2:0], strap_in_i[i]};
            end
        end
    end

    function automatic logic [CLS_W-1:0] classify(input logic [PAT_LEN-1:0] seen);
        logic [CLS_W-1:0] c;
        c = CLS_W'(SCAP_TIE_LOW);
        unique case (seen)
            PAT_HIGH: c = CLS_W'(SCAP_TIE_HIGH);
            PAT_DRIVE_0: c = CLS_W'(SCAP_DRIVE_0);
            PAT_DRIVE_1: c = CLS_W'(SCAP_DRIVE_1);
            PAT_DRIVE_2: c = CLS_W'(SCAP_DRIVE_2);
            PAT_DRIVE_3: c = CLS_W'(SCAP_DRIVE_3);
            default: c = CLS_W'(SCAP_TIE_LOW);
        endcase
        return c;
    endfunction

    // decoded settings latched at the end of the phase and held until reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < STRAP_COUNT; i++) begin
                strap_class[i] <= CLS_W'(SCAP_TIE_LOW);
            end
            config_busy_o <= 1'b1;
        end else if (!system_reset_n_i) begin
            config_busy_o <= 1'b1;
        end else if (state == SCAP_RUN && config_busy_o) begin
            for (int i = 0; i < STRAP_COUNT; i++) begin
                // the last pattern bit is still on the pin, so it is taken from there
                strap_class[i] <= classify({capture[i][PAT_LEN-2:0],
                    strap_in_i[i]});
            end
            config_busy_o <= 1'b0;
        end
    end

    // each pair of six-valued classes gives 36 combinations, folded into a 4-bit code of up to 16 settings;
    // the table mapping codes to rates lives outside this block
    function automatic logic [3:0] pair_code(input logic [CLS_W-1:0] lo,
                                             input logic [CLS_W-1:0] hi);
        logic [5:0] full;
        full = 6'(hi) * 6'h06 + 6'(lo);
        return full[3:0] ^ {2'h0, full[5:4]};
    endfunction

    // code outputs follow the latched classes one edge later
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rate_set_ab_o <= 4'h0;
        end else begin
            rate_set_ab_o <= pair_code(strap_class[0], strap_class[1]);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            divider_pad_ab_o <= 4'h0;
        end else begin
            divider_pad_ab_o <= pair_code(strap_class[2], strap_class[3]);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_freq_cd_o <= 4'h0;
        end else begin
            sync_freq_cd_o <= pair_code(strap_class[4], strap_class[5]);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            odd_lock_pad_cd_o <= 4'h0;
        end else begin
            odd_lock_pad_cd_o <= pair_code(strap_class[6], strap_class[7]);
        end
    end

    // both straps tied low disables the lock detector
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_enable <= 1'b0;
        end else begin
            lock_enable <= !(strap_class[6] == CLS_W'(SCAP_TIE_LOW)
                && strap_class[7] == CLS_W'(SCAP_TIE_LOW));
        end
    end

    // pins act as strap drives during configuration, then drives 0, 1 and 3 as alarms and drive 2 held low;
    // a system reset silences them on the next clock edge so no half pattern stays on the board
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_a_fail_strap_drive_o <= 1'b0;
        end else if (!system_reset_n_i) begin
            ref_a_fail_strap_drive_o <= 1'b0;
        end else if (state == SCAP_DRIVE) begin
            ref_a_fail_strap_drive_o <= PAT_DRIVE_0[PAT_LEN-1-step];
        end else if (state == SCAP_RUN && !config_busy_o) begin
            ref_a_fail_strap_drive_o <= ref_a_fail_i;
        end else begin
            ref_a_fail_strap_drive_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_b_fail_strap_drive_o <= 1'b0;
        end else if (!system_reset_n_i) begin
            ref_b_fail_strap_drive_o <= 1'b0;
        end else if (state == SCAP_DRIVE) begin
            ref_b_fail_strap_drive_o <= PAT_DRIVE_1[PAT_LEN-1-step];
        end else if (state == SCAP_RUN && !config_busy_o) begin
            ref_b_fail_strap_drive_o <= ref_b_fail_i;
        end else begin
            ref_b_fail_strap_drive_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            strap_drive_2_o <= 1'b0;
        end else if (!system_reset_n_i) begin
            strap_drive_2_o <= 1'b0;
        end else if (state == SCAP_DRIVE) begin
            strap_drive_2_o <= PAT_DRIVE_2[PAT_LEN-1-step];
        end else if (state == SCAP_RUN && !config_busy_o) begin
            strap_drive_2_o <= 1'b0;
        end else begin
            strap_drive_2_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            selected_ref_fail_strap_drive_o <= 1'b0;
        end else if (!system_reset_n_i) begin
            selected_ref_fail_strap_drive_o <= 1'b0;
        end else if (state == SCAP_DRIVE) begin
            selected_ref_fail_strap_drive_o <= PAT_DRIVE_3[PAT_LEN-1-step];
        end else if (state == SCAP_RUN && !config_busy_o) begin
            selected_ref_fail_strap_drive_o <= ref_b_selected_i ? ref_b_fail_i
                : ref_a_fail_i;
        end else begin
            selected_ref_fail_strap_drive_o <= 1'b0;
        end
    end

    // free-running sawtooth; output high while it is below the error
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwm_count <= '0;
            phase_lock_indicator_o <= 1'b0;
        end else begin
            pwm_count <= pwm_count + 1'b1;
            if (!lock_enable || config_busy_o || control[0]) begin
                phase_lock_indicator_o <= 1'b0;
            end else begin
                phase_lock_indicator_o <= pwm_count < phase_error_i;
            end
        end
    end

    // register bus: one wait cycle on every access keeps read data registered
    logic bus_take;
    assign bus_take = (avs_read_i || avs_write_i) && avs_waitrequest_o;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !bus_take;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (bus_take && avs_read_i) begin
            unique case (avs_address_i)
                ADDR_CONFIG: avs_readdata_o <= {16'h0000, odd_lock_pad_cd_o,
                    sync_freq_cd_o, divider_pad_ab_o, rate_set_ab_o};
                ADDR_STATUS: avs_readdata_o <= {27'h0, lock_enable,
                    selected_ref_fail_strap_drive_o, ref_b_fail_strap_drive_o,
                    ref_a_fail_strap_drive_o, config_busy_o};
                ADDR_CONTROL: avs_readdata_o <= control;
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            control <= CONTROL_RESET;
        end else if (bus_take && avs_write_i && avs_address_i == ADDR_CONTROL) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    control[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
                end
            end
        end
    end
endmodule

/* File: verif/scap_strap_config_checker.sv */
// concurrent checks for the strap configuration and alarm block
`timescale 1ns/1ps
module scap_strap_config_checker
    import scap_pkg::*;
#(
    parameter int PHASE_W = 8
) (
    input wire logic clk_i, // clock
    input wire logic reset_i, // power-up reset
    input wire logic system_reset_n_i, // system reset
    input wire logic ref_a_fail_i, // ref a lost
    input wire logic ref_b_fail_i, // ref b lost
    input wire logic ref_b_selected_i, // b selected
    input wire logic [PHASE_W-1:0] phase_error_i, // phase error
    input wire logic ref_a_fail_strap_drive_o, // drive 0
    input wire logic ref_b_fail_strap_drive_o, // drive 1
    input wire logic strap_drive_2_o, // drive 2
    input wire logic selected_ref_fail_strap_drive_o, // drive 3
    input wire logic phase_lock_indicator_o, // lock pulse
    input wire logic config_busy_o, // busy
    input wire logic [3:0] rate_set_ab_o, // code
    input wire logic [3:0] divider_pad_ab_o, // code
    input wire logic [3:0] sync_freq_cd_o, // code
    input wire logic [3:0] odd_lock_pad_cd_o // code
);
    logic sel_src;
    logic idle;
    logic [15:0] codes;
    assign sel_src = ref_b_selected_i ? ref_b_fail_i : ref_a_fail_i;
    assign idle = !config_busy_o;
    assign codes = {odd_lock_pad_cd_o, sync_freq_cd_o, divider_pad_ab_o, rate_set_ab_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_sel_alarm_follow: assert property (idle && $past(idle) |->
        selected_ref_fail_strap_drive_o == $past(sel_src)) else $error("selected alarm wrong");
    a_ref_a_alarm: assert property (idle && $past(idle) |->
        ref_a_fail_strap_drive_o == $past(ref_a_fail_i)) else $error("ref a alarm wrong");
    a_ref_b_alarm: assert property (idle && $past(idle) |->
        ref_b_fail_strap_drive_o == $past(ref_b_fail_i)) else $error("ref b alarm wrong");
    a_drive2_quiet: assert property (idle && $past(idle) |-> !strap_drive_2_o)
        else $error("drive 2 active outside configuration");
    a_lock_zero_err: assert property (phase_error_i == '0 && $past(phase_error_i) == '0
        |-> !phase_lock_indicator_o) else $error("lock pulse with zero error");
    a_busy_on_sysrst: assert property (!system_reset_n_i |=> config_busy_o)
        else $error("system reset did not restart configuration");
    a_drives_sysrst: assert property (!system_reset_n_i |=> !(ref_a_fail_strap_drive_o ||
        ref_b_fail_strap_drive_o || strap_drive_2_o || selected_ref_fail_strap_drive_o))
        else $error("drives not cleared by system reset");
    a_config_len: assert property ($rose(system_reset_n_i) |->
        config_busy_o [*8] ##[1:4] !config_busy_o) else $error("configuration length wrong");
    a_codes_hold: assert property (idle && !$past(config_busy_o) && !$past(config_busy_o, 2)
        && $past(system_reset_n_i) |-> $stable(codes)) else $error("latched codes changed");
    cover property ($fell(config_busy_o));
    cover property (phase_lock_indicator_o);
    cover property (idle && selected_ref_fail_strap_drive_o);
endmodule

bind scap_strap_config scap_strap_config_checker #(.PHASE_W(PHASE_W)) i_chk (.clk_i(clk_i),
    .reset_i(reset_i), .system_reset_n_i(system_reset_n_i), .ref_a_fail_i(ref_a_fail_i),
    .ref_b_fail_i(ref_b_fail_i), .ref_b_selected_i(ref_b_selected_i),
    .phase_error_i(phase_error_i), .ref_a_fail_strap_drive_o(ref_a_fail_strap_drive_o),
    .ref_b_fail_strap_drive_o(ref_b_fail_strap_drive_o), .strap_drive_2_o(strap_drive_2_o),
    .selected_ref_fail_strap_drive_o(selected_ref_fail_strap_drive_o),
    .phase_lock_indicator_o(phase_lock_indicator_o), .config_busy_o(config_busy_o),
    .rate_set_ab_o(rate_set_ab_o), .divider_pad_ab_o(divider_pad_ab_o),
    .sync_freq_cd_o(sync_freq_cd_o), .odd_lock_pad_cd_o(odd_lock_pad_cd_o));

/* File: verif/scap_strap_board.sv */
// board strap wiring: each strap tied low, tied high or wired to one drive
`timescale 1ns/1ps
module scap_strap_board
    import scap_pkg::*;
(
    input wire logic [scap_pkg::DRIVE_COUNT-1:0] drive_i, // drives 0..3
    input wire scap_pkg::scap_class_t cls_i [scap_pkg::STRAP_COUNT], // wiring of each strap
    output logic [scap_pkg::STRAP_COUNT-1:0] strap_in_o // strap levels
);
    always_comb begin
        for (int k = 0; k < STRAP_COUNT; k++) begin
            case (cls_i[k])
                SCAP_TIE_LOW: strap_in_o[k] = 1'b0;
                SCAP_TIE_HIGH: strap_in_o[k] = 1'b1;
                default: strap_in_o[k] = drive_i[int'(cls_i[k]) - 2];
            endcase
        end
    end
endmodule

/* File: verif/scap_strap_config_tb.sv */
// self-checking bench for the strap configuration and alarm block
`timescale 1ns/1ps
module scap_strap_config_tb;
    import scap_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, system_reset_n_i = 1'b1, seen;
    logic ref_a_fail_i = 1'b0, ref_b_fail_i = 1'b0, ref_b_selected_i = 1'b0;
    logic [7:0] phase_error_i = 8'h00;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, busy, lock, d_a, d_b, d_2, d_s, wreq;
    logic [31:0] avs_writedata_i = 32'h0, rdata, rd, exp;
    logic [7:0] strap;
    logic [3:0] c_r, c_d, c_s, c_o;
    scap_class_t cls [STRAP_COUNT];
    int num_errors = 0, n_compared = 0, cycles = 0;
    // strap classes 0..7, then the expected lock detector enable
    int rows [4][9] = '{'{0, 0, 0, 0, 0, 0, 0, 0, 0}, '{0, 1, 2, 3, 4, 5, 1, 2, 1},
        '{5, 4, 3, 2, 1, 0, 3, 0, 1}, '{1, 1, 4, 4, 5, 0, 0, 5, 1}};
    scap_strap_config i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .system_reset_n_i(system_reset_n_i), .strap_in_i(strap), .ref_a_fail_i(ref_a_fail_i),
        .ref_b_fail_i(ref_b_fail_i), .ref_b_selected_i(ref_b_selected_i),
        .phase_error_i(phase_error_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .ref_a_fail_strap_drive_o(d_a),
        .ref_b_fail_strap_drive_o(d_b), .strap_drive_2_o(d_2),
        .selected_ref_fail_strap_drive_o(d_s), .phase_lock_indicator_o(lock),
        .config_busy_o(busy), .rate_set_ab_o(c_r), .divider_pad_ab_o(c_d),
        .sync_freq_cd_o(c_s), .odd_lock_pad_cd_o(c_o));
    scap_strap_board i_board (.drive_i({d_s, d_2, d_b, d_a}), .cls_i(cls), .strap_in_o(strap));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, want);
        end
    endtask
    function automatic logic [3:0] pcode(input int hi, input int lo);
        logic [5:0] v;
        v = 6'(hi * 6 + lo);
        return v[3:0] ^ {2'b00, v[5:4]};
    endfunction
    // entered just after an edge; waitrequest is read before the edge's updates land
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rd = rdata;
        chk(32'(n < 20), 32'h1);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 40);
        chk(32'(n < 40), 32'h1);
        repeat (2) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        foreach (cls[k]) cls[k] = SCAP_TIE_LOW;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        chk(32'({busy, d_a, d_b, d_2, d_s}), 32'h10);
        phase_error_i <= 8'h80;
        for (int r = 0; r < 4; r++) begin
            foreach (cls[k]) cls[k] <= scap_class_t'(rows[r][k]);
            system_reset_n_i <= 1'b0;
            @(posedge clk_i);
            system_reset_n_i <= 1'b1;
            wait_idle();
            exp = {16'h0, pcode(rows[r][7], rows[r][6]), pcode(rows[r][5], rows[r][4]),
                pcode(rows[r][3], rows[r][2]), pcode(rows[r][1], rows[r][0])};
            chk(c_r, exp[3:0]);
            chk(c_d, exp[7:4]);
            chk(c_s, exp[11:8]);
            chk(c_o, exp[15:12]);
            bus(1'b0, ADDR_CONFIG, 32'h0);
            chk(rd, exp);
            seen = 1'b0;
            repeat (300) @(posedge clk_i) seen |= lock;
            chk(seen, rows[r][8]);
        end
        bus(1'b1, ADDR_CONFIG, 32'hFFFF);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, exp);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h10);
        bus(1'b1, ADDR_CONTROL, 32'h1);
        bus(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd, 32'h1);
        seen = 1'b0;
        repeat (300) @(posedge clk_i) seen |= lock;
        chk(seen, 1'b0);
        phase_error_i <= 8'h00;
        bus(1'b1, ADDR_CONTROL, 32'h0);
        seen = 1'b0;
        repeat (300) @(posedge clk_i) seen |= lock;
        chk(seen, 1'b0);
        for (int i = 0; i < 8; i++) begin
            {ref_b_selected_i, ref_b_fail_i, ref_a_fail_i} <= 3'(i);
            repeat (3) @(posedge clk_i);
            chk({d_s, d_b, d_a, d_2}, {i[2] ? i[1] : i[0], i[1], i[0], 1'b0});
        end
        // power-up again in mid-run must relearn the same straps
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(32'({busy, c_r, d_a, d_s}), 32'h40);
        reset_i <= 1'b0;
        wait_idle();
        chk({c_o, c_s, c_d, c_r}, exp);
        final_report();
    end
endmodule
